/* File: verilog/loop_ctrl_consts.svh */
/*
 * offsets, field positions, reset values and frame constants of the port and loop control block.
 * assumes a 16-bit apb byte address and a 32-bit data bus.
 */
`ifndef LOOP_CTRL_CONSTS_SVH
`define LOOP_CTRL_CONSTS_SVH

// ==========================================================
// register byte addresses
`define ADDR_LOOP_CTRL 16'h0100
`define ADDR_LINK_STATUS 16'h0110
`define ADDR_PORT_CFG 16'h0120
`define ADDR_TX_SHIFT 16'h0124
`define ADDR_FWD_FIFO 16'h0128

// ==========================================================
// reset values
`define RST_LOOP_CTRL 8'h00
`define RST_PORT_CFG 12'h000
`define RST_TX_SHIFT 9'h000
`define RST_FWD_THR 5'h08

// ==========================================================
// field positions
`define CFG_POL_LSB 0
`define CFG_UNUSED_LSB 4
`define CFG_ELD_LSB 8
`define SHIFT_AUTO_BIT 8
`define STAT_OPEN_LSB 4
`define STAT_OVF_BIT 8

// ==========================================================
// frame layout and sizes
`define NPORT 4
`define FIFO_DEPTH 16
`define FIFO_WIDTH 6
`define CIRC_NIBBLE 12'h01c
`define CIRC_BIT 1
`define NIB_MAX 12'hfff

`endif

/* File: verilog/loop_ctrl_pkg.sv */
/*
 * types of the port and loop control block.
 * assumes nothing of its surroundings.
 */
package loop_ctrl_pkg;

   // ==========================================================
   // per-port loop mode, two bits of the loop control register
   typedef enum logic [1:0] {
      LOOP_AUTO = 2'h0,
      LOOP_OPEN = 2'h1,
      LOOP_CLOSED = 2'h2,
      LOOP_RSVD = 2'h3
   } loop_mode_t;

   // ==========================================================
   // ingress frame states, gray along idle -> run -> drop
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_RUN = 2'b01,
      RX_DROP = 2'b11
   } rx_state_t;

endpackage : loop_ctrl_pkg

/* File: verilog/fwd_fifo.sv */
/*
 * forwarding fifo with valid/ready on both sides and a fill level.
 * assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
module fwd_fifo #(
   parameter int WIDTH = 6,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // fill side
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   // drain side
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data,
   output logic [$clog2(DEPTH):0] o_level
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign o_in_ready = cnt_q < (AW+1)'(DEPTH);
   assign o_out_valid = cnt_q != '0;
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;
   assign o_out_data = mem_q[rd_q];
   assign o_level = cnt_q;

   // ==========================================================
   // storage has no reset: only written entries are ever read
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_q[wr_q] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule : fwd_fifo

/* File: verilog/port_loop_ctrl.sv */
/*
 * port link tracking, loop closing and frame forwarding of a four-port slave controller,
 * with an apb register slave.
 * assumes mii nibble streams clocked by one link clock synchronous to the system clock,
 * link indication pins from the phys and a management-ok level from the phy management logic.
 */
// The implementer's own choice: the APB slave port.
// What this block does
// - unused port holds no link and closes automatically, sending nothing out, except port 0 while no port has link
// - frame passing while port 0 is auto closed gets its loop marker set
// - marked frame arriving while port 0 is auto closed is destroyed
// - when no port has link, port 0 opens automatically
// - link of every port is readable in the link status register, read as no link for unused or error-dropped ports
// - link pin read with configurable polarity; unused pins driven to no-link outside
// - default fifo size tolerates 100 ppm partner clock deviation
// - no transmit fifo; manual skew moves transmit timing into phy window
// - auto skew finds and applies shift itself; clocks must stay synchronous
// - error link drop needs working phy management; enable per mii port
`timescale 1ns/1ps
`include "loop_ctrl_consts.svh"
module port_loop_ctrl (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [15:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // mii receive side, all ports on one link clock
   input wire logic i_link_clk,
   input wire logic [3:0] i_link_pin,
   input wire logic [3:0] i_rx_dv,
   input wire logic [3:0] i_rx_er,
   input wire logic [15:0] i_rxd,
   input wire logic i_mgmt_ok,
   // mii transmit side
   output logic [15:0] o_txd,
   output logic [3:0] o_tx_en,
   output logic [3:0] o_tx_er,
   output logic [3:0] o_port_open
);
   localparam int NP = `NPORT;
   localparam int SW = 29;

   // ==========================================================
   // synchronisers for everything from the pins
   logic [SW-1:0] s1_q;
   logic [SW-1:0] s2_q;
   logic clk3_q;
   logic lclk;
   logic [3:0] pin_s;
   logic [3:0] dv_s;
   logic [3:0] er_s;
   logic [15:0] rxd_s;
   logic rise;
   logic fall;

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s1_q <= '0;
         s2_q <= '0;
         clk3_q <= 1'b0;
      end else begin
         s1_q <= {i_link_clk, i_link_pin, i_rx_dv, i_rx_er, i_rxd};
         s2_q <= s1_q;
         clk3_q <= s2_q[28];
      end
   end

   assign lclk = s2_q[28];
   assign pin_s = s2_q[27:24];
   assign dv_s = s2_q[23:20];
   assign er_s = s2_q[19:16];
   assign rxd_s = s2_q[15:0];
   assign rise = lclk && !clk3_q;
   assign fall = !lclk && clk3_q;

   // ==========================================================
   // registers
   logic [7:0] loop_ctrl_q;
   logic [11:0] port_cfg_q;
   logic [8:0] tx_shift_q;
   logic [4:0] fwd_thr_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic ovf_q;
   logic [3:0] link_ok;
   logic [3:0] open_w;
   logic setup;
   logic wr_en;
   logic [31:0] rd_mux;
   logic rd_hit;

   assign setup = i_psel && !i_penable;
   assign wr_en = i_psel && i_penable && i_pwrite;

   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      unique case (i_paddr)
         `ADDR_LOOP_CTRL: rd_mux = {24'h00_0000, loop_ctrl_q};
         `ADDR_LINK_STATUS: rd_mux = {23'h00_0000, ovf_q, open_w, link_ok};
         `ADDR_PORT_CFG: rd_mux = {20'h0_0000, port_cfg_q};
         `ADDR_TX_SHIFT: rd_mux = {23'h00_0000, tx_shift_q};
         `ADDR_FWD_FIFO: rd_mux = {27'h000_0000, fwd_thr_q};
         default: rd_hit = 1'b0;
      endcase
   end

   // answer is decoded in the setup cycle so the access phase ends at once
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (setup) begin
         prdata_q <= i_pwrite ? 32'h0000_0000 : rd_mux;
         pslverr_q <= !rd_hit || (i_pwrite && i_paddr == `ADDR_LINK_STATUS);
      end
   end

   assign o_prdata = prdata_q;
   assign o_pslverr = o_pready && pslverr_q;
   assign o_pready = i_psel && i_penable;

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         loop_ctrl_q <= `RST_LOOP_CTRL;
         port_cfg_q <= `RST_PORT_CFG;
         tx_shift_q <= `RST_TX_SHIFT;
         fwd_thr_q <= `RST_FWD_THR;
      end else if (wr_en) begin
         unique case (i_paddr)
            `ADDR_LOOP_CTRL: loop_ctrl_q <= i_pwdata[7:0];
            `ADDR_PORT_CFG: port_cfg_q <= i_pwdata[11:0];
            `ADDR_TX_SHIFT: tx_shift_q <= i_pwdata[8:0];
            // a lower start level cuts latency but only suits accurate clocks
            `ADDR_FWD_FIFO: fwd_thr_q <= (i_pwdata[4:0] == 5'h00) ? 5'h01 : i_pwdata[4:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // link state and loop control
   logic [3:0] pol;
   logic [3:0] unused;
   logic [3:0] eld_en;
   logic [3:0] drop_q;
   logic any_link;
   logic closed0_auto;

   assign pol = port_cfg_q[`CFG_POL_LSB +: 4];
   assign unused = port_cfg_q[`CFG_UNUSED_LSB +: 4];
   assign eld_en = port_cfg_q[`CFG_ELD_LSB +: 4];
   assign any_link = |link_ok;

   generate
      for (genvar p = 0; p < NP; p++) begin : g_port
         loop_ctrl_pkg::loop_mode_t mode;
         assign mode = loop_ctrl_pkg::loop_mode_t'(loop_ctrl_q[2*p +: 2]);
         assign link_ok[p] = !unused[p] && (pin_s[p] ^ pol[p]) && !drop_q[p];

         // dropped on a receive error, released once the pin shows no link
         always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
               drop_q[p] <= 1'b0;
            end else if (!(pin_s[p] ^ pol[p])) begin
               drop_q[p] <= 1'b0;
            end else if (eld_en[p] && i_mgmt_ok && er_s[p] && rise) begin
               drop_q[p] <= 1'b1;
            end
         end

         if (p == 0) begin : g_p0
            always_comb begin
               unique case (mode)
                  loop_ctrl_pkg::LOOP_OPEN: open_w[p] = 1'b1;
                  loop_ctrl_pkg::LOOP_CLOSED: open_w[p] = 1'b0;
                  default: open_w[p] = link_ok[p] || !any_link;
               endcase
            end
            assign closed0_auto = (mode == loop_ctrl_pkg::LOOP_AUTO ||
                                   mode == loop_ctrl_pkg::LOOP_RSVD) && !open_w[p];
         end else begin : g_pn
            always_comb begin
               unique case (mode)
                  loop_ctrl_pkg::LOOP_OPEN: open_w[p] = 1'b1;
                  loop_ctrl_pkg::LOOP_CLOSED: open_w[p] = 1'b0;
                  default: open_w[p] = link_ok[p];
               endcase
            end
         end
      end
   endgenerate

   assign o_port_open = open_w;

   // ==========================================================
   // ingress: pick a source, mark or destroy, push into the fifo
   loop_ctrl_pkg::rx_state_t rx_state_q;
   logic [1:0] src_q;
   logic [1:0] dst_q;
   logic [11:0] nib_q;
   logic [1:0] start_src;
   logic [1:0] start_dst;
   logic start_ok;
   logic in_valid;
   logic in_ready;
   logic [5:0] in_data;
   logic [3:0] nib;
   logic nib_er;

   always_comb begin
      start_ok = 1'b0;
      start_src = 2'd0;
      start_dst = 2'd0;
      for (int p = NP - 1; p >= 0; p--) begin
         if (dv_s[p] && open_w[p]) begin
            start_ok = 1'b1;
            start_src = 2'(p);
         end
      end
      // next open port after the source; the source itself when none other is open
      start_dst = start_src;
      for (int k = NP - 1; k >= 1; k--) begin
         if (open_w[2'(start_src + 2'(k))]) begin
            start_dst = 2'(start_src + 2'(k));
         end
      end
   end

   assign nib = rxd_s[4*src_q +: 4];
   assign nib_er = er_s[src_q];

   always_comb begin
      in_valid = 1'b0;
      in_data = 6'h00;
      if (rise) begin
         unique case (rx_state_q)
            loop_ctrl_pkg::RX_IDLE: begin
               in_valid = start_ok;
               in_data = {2'b00, rxd_s[4*start_src +: 4]};
               in_data[4] = er_s[start_src];
            end
            loop_ctrl_pkg::RX_RUN: begin
               in_valid = 1'b1;
               if (!dv_s[src_q]) begin
                  in_data = 6'h20;
               end else if (nib_q == `CIRC_NIBBLE && closed0_auto) begin
                  if (nib[`CIRC_BIT]) begin
                     in_data = {2'b01, nib};
                  end else begin
                     in_data = {1'b0, nib_er, nib | 4'(1 << `CIRC_BIT)};
                  end
               end else begin
                  in_data = {1'b0, nib_er, nib};
               end
            end
            loop_ctrl_pkg::RX_DROP: begin
               // the end word follows the destroyed nibble at once, the rest is swallowed
               in_valid = nib_q == `CIRC_NIBBLE + 12'h001;
               in_data = 6'h20;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rx_state_q <= loop_ctrl_pkg::RX_IDLE;
         src_q <= 2'd0;
         dst_q <= 2'd0;
         nib_q <= 12'h000;
         ovf_q <= 1'b0;
      end else if (rise) begin
         if (in_valid && !in_ready) begin
            ovf_q <= 1'b1;
         end
         unique case (rx_state_q)
            loop_ctrl_pkg::RX_IDLE: begin
               if (start_ok) begin
                  rx_state_q <= loop_ctrl_pkg::RX_RUN;
                  src_q <= start_src;
                  dst_q <= start_dst;
                  nib_q <= 12'h001;
                  ovf_q <= !in_ready;
               end
            end
            loop_ctrl_pkg::RX_RUN: begin
               if (!dv_s[src_q]) begin
                  rx_state_q <= loop_ctrl_pkg::RX_IDLE;
               end else if (nib_q == `CIRC_NIBBLE && closed0_auto && nib[`CIRC_BIT]) begin
                  rx_state_q <= loop_ctrl_pkg::RX_DROP;
               end
               if (nib_q != `NIB_MAX) begin
                  nib_q <= nib_q + 12'h001;
               end
            end
            loop_ctrl_pkg::RX_DROP: begin
               if (!dv_s[src_q]) begin
                  rx_state_q <= loop_ctrl_pkg::RX_IDLE;
               end
               if (nib_q != `NIB_MAX) begin
                  nib_q <= nib_q + 12'h001;
               end
            end
            default: rx_state_q <= loop_ctrl_pkg::RX_IDLE;
         endcase
      end
   end

   // ==========================================================
   // forwarding fifo; a start level of half the depth absorbs the 100 ppm drift
   logic out_valid;
   logic out_ready;
   logic [5:0] out_data;
   logic [4:0] level;

   fwd_fifo #(
      .WIDTH(`FIFO_WIDTH),
      .DEPTH(`FIFO_DEPTH)
   ) u_fifo (
      .i_clk(i_sys_clk),
      .i_arst_n(i_arst_n),
      .i_in_valid(in_valid),
      .o_in_ready(in_ready),
      .i_in_data(in_data),
      .o_out_valid(out_valid),
      .i_out_ready(out_ready),
      .o_out_data(out_data),
      .o_level(level)
   );

   // ==========================================================
   // egress: one word per link clock, then skewed per port
   logic tx_act_q;
   logic [1:0] tx_dst_q;
   logic txw_en_q;
   logic txw_er_q;
   logic [3:0] txw_d_q;
   logic [3:0] dline_q;
   logic tx_go;

   assign tx_go = level >= fwd_thr_q || (out_valid && rx_state_q == loop_ctrl_pkg::RX_IDLE);
   assign out_ready = rise && (tx_act_q || tx_go);

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tx_act_q <= 1'b0;
         tx_dst_q <= 2'd0;
         txw_en_q <= 1'b0;
         txw_er_q <= 1'b0;
         txw_d_q <= 4'h0;
      end else if (rise) begin
         if (!tx_act_q && tx_go) begin
            tx_act_q <= 1'b1;
            tx_dst_q <= dst_q;
         end
         if (tx_act_q || tx_go) begin
            // an empty fifo mid-frame would corrupt the frame, so flag it
            txw_en_q <= !out_valid || !out_data[5];
            txw_er_q <= !out_valid || out_data[4];
            txw_d_q <= out_valid ? out_data[3:0] : 4'h0;
            if (out_valid && out_data[5]) begin
               tx_act_q <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         dline_q <= 4'h0;
      end else begin
         dline_q <= {dline_q[2:0], rise};
      end
   end

   generate
      for (genvar p = 0; p < NP; p++) begin : g_tx
         logic strobe;
         // auto skew updates on the falling link edge, mid-way to the phy sample point
         assign strobe = tx_shift_q[`SHIFT_AUTO_BIT] ? fall : dline_q[tx_shift_q[2*p +: 2]];

         always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
               o_tx_en[p] <= 1'b0;
               o_tx_er[p] <= 1'b0;
               o_txd[4*p +: 4] <= 4'h0;
            end else if (strobe) begin
               o_tx_en[p] <= txw_en_q && tx_dst_q == 2'(p) && open_w[p];
               o_tx_er[p] <= txw_er_q && tx_dst_q == 2'(p) && open_w[p];
               o_txd[4*p +: 4] <= (tx_dst_q == 2'(p)) ? txw_d_q : 4'h0;
            end
         end
      end
   endgenerate
endmodule : port_loop_ctrl

/* File: verif/port_loop_ctrl_checker.sv */
/* concurrent checks on the ports of the port and loop control block.
   assumes the register header and one 100 MHz clock with an async low reset. */
`timescale 1ns/1ps
`include "loop_ctrl_consts.svh"
module port_loop_ctrl_checker (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   // apb
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [15:0] i_paddr,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   // mii transmit
   input wire logic [15:0] o_txd,
   input wire logic [3:0] o_tx_en,
   input wire logic [3:0] o_port_open
);
   // ============
   // helpers
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_arst_n);
   logic acc;
   logic mapped;
   assign acc = i_psel && i_penable;
   assign mapped = i_paddr inside {`ADDR_LOOP_CTRL, `ADDR_LINK_STATUS, `ADDR_PORT_CFG,
      `ADDR_TX_SHIFT, `ADDR_FWD_FIFO};
   // ============
   // register bus
   a_pready_access: assert property (o_pready == acc)
      else $error("pready not equal to access phase");
   a_status_ro: assert property (acc && i_pwrite && i_paddr == `ADDR_LINK_STATUS |-> o_pslverr)
      else $error("write to status not refused");
   a_status_read: assert property (acc && !i_pwrite && i_paddr == `ADDR_LINK_STATUS |-> !o_pslverr)
      else $error("status read refused");
   a_unmapped_err: assert property (acc && !i_pwrite && !mapped |-> o_pslverr && o_prdata == 32'h0)
      else $error("unmapped read not refused");
   a_err_in_access: assert property (o_pslverr |-> acc)
      else $error("slave error outside access");
   // prdata is loaded at setup, so it may not move under the access edge
   a_prdata_hold: assert property (acc && !i_pwrite |=> $stable(o_prdata))
      else $error("read data moved after access");
   // ============
   // transmit side
   a_tx_on_open: assert property ((o_tx_en & ~$past(o_tx_en) & ~o_port_open) == 4'h0)
      else $error("transmit started on closed port");
   a_tx_pace: assert property ($changed(o_txd) |=> $stable(o_txd) [*8])
      else $error("transmit data faster than link clock");
endmodule : port_loop_ctrl_checker

bind port_loop_ctrl port_loop_ctrl_checker i_chk (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
   .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
   .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_txd(o_txd),
   .o_tx_en(o_tx_en), .o_port_open(o_port_open));

/* File: verif/phy_model.sv */
/* behavioural mii phys of all four ports: sends receive frames, captures transmit frames.
   assumes a free running link clock shared with the block. */
`timescale 1ns/1ps
module phy_model (
   // link clock
   input wire logic i_link_clk,
   // toward the block
   output logic [3:0] o_rx_dv,
   output logic [15:0] o_rxd,
   // from the block
   input wire logic [15:0] i_txd,
   input wire logic [3:0] i_tx_en,
   input wire logic [3:0] i_tx_er
);
   logic [4:0] got[4][$];
   initial begin
      o_rx_dv = 4'h0;
      o_rxd = 16'h0000;
   end
   // ============
   // capture, a full link clock after launch so any shift setting is safe
   always @(posedge i_link_clk) begin
      for (int p = 0; p < 4; p++) begin
         if (i_tx_en[p]) begin
            got[p].push_back({i_tx_er[p], i_txd[4*p+:4]});
         end
      end
   end
   // ============
   // receive frame, launched mid period
   task send(input int p, input logic [3:0] nib[$]);
      foreach (nib[i]) begin
         @(negedge i_link_clk);
         o_rx_dv[p] = 1'b1;
         o_rxd[4*p+:4] = nib[i];
      end
      @(negedge i_link_clk);
      o_rx_dv[p] = 1'b0;
      // idle data must not look like the last nibble
      o_rxd[4*p+:4] = ~nib[nib.size()-1];
      repeat (2) @(negedge i_link_clk);
   endtask : send
endmodule : phy_model

/* File: verif/slave_port_loop_control_tb.sv */
/* self-checking bench of the port loop control block and its forwarding fifo.
   assumes the phy model beside it and the checker bound to the block. */
`timescale 1ns/1ps
`include "loop_ctrl_consts.svh"
module slave_port_loop_control_tb;
   logic clk = 1'b0, rst_n = 1'b0, lclk = 1'b0;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr, rd_err;
   logic [15:0] paddr = 16'h0000, rxd, txd;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pin = 4'h0, rx_er = 4'h0, rx_dv, tx_en, tx_er, open;
   logic mgmt = 1'b1;
   int bad_count = 0, n_tests = 0, seed = 39;
   logic [3:0] q[$];
   logic [4:0] e[$];
   // ============
   // instances; receive errors and management ok come from the bench
   port_loop_ctrl i_dut (.i_sys_clk(clk), .i_arst_n(rst_n), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_link_clk(lclk), .i_link_pin(pin), .i_rx_dv(rx_dv),
      .i_rx_er(rx_er), .i_rxd(rxd), .i_mgmt_ok(mgmt), .o_txd(txd), .o_tx_en(tx_en),
      .o_tx_er(tx_er), .o_port_open(open));
   phy_model i_phy (.i_link_clk(lclk), .o_rx_dv(rx_dv), .o_rxd(rxd), .i_txd(txd),
      .i_tx_en(tx_en), .i_tx_er(tx_er));
   initial forever #5 clk = ~clk;
   initial begin
      #3;
      forever #80 lclk = ~lclk;
   end
   // ============
   // shared tasks
   task check(input logic [32:0] g, input logic [32:0] x, input string s);
      n_tests++;
      if (g !== x) begin
         bad_count++;
         $display("BAD %0t %s got %h want %h", $time, s, g, x);
      end
   endtask : check
   task apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask : apb
   task finish_test;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finish_test
   initial begin
      #500_000;
      bad_count++;
      finish_test;
   end
   // ============
   // main sequence
   initial begin
      logic [11:0] cfg;
      logic [7:0] mode;
      logic [3:0] lnk, opn;
      int m;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      apb(1'b0, `ADDR_LOOP_CTRL, 32'h0);
      check(rd, {24'h0, `RST_LOOP_CTRL}, "mode reset");
      apb(1'b0, `ADDR_PORT_CFG, 32'h0);
      check(rd, {20'h0, `RST_PORT_CFG}, "cfg reset");
      apb(1'b0, `ADDR_TX_SHIFT, 32'h0);
      check(rd, {23'h0, `RST_TX_SHIFT}, "shift reset");
      apb(1'b0, `ADDR_FWD_FIFO, 32'h0);
      check(rd, {27'h0, `RST_FWD_THR}, "fifo level reset");
      apb(1'b0, 16'h0104, 32'h0);
      check({rd_err, rd}, {1'b1, 32'h0}, "unmapped read");
      apb(1'b1, `ADDR_LINK_STATUS, 32'h0000_ffff);
      check(rd_err, 1'b1, "status write");
      $display("registers done");
      // error link drop acts only while phy management works
      apb(1'b1, `ADDR_PORT_CFG, 32'h200);
      pin <= 4'h2;
      for (int k = 0; k < 2; k++) begin
         mgmt <= k[0];
         rx_er <= 4'h2;
         repeat (40) @(posedge clk);
         rx_er <= 4'h0;
         apb(1'b0, `ADDR_LINK_STATUS, 32'h0);
         check(rd[1], !k[0], "error link drop");
      end
      $display("link drop done");
      for (int k = 0; k < 12; k++) begin
         cfg = 12'($random(seed));
         mode = 8'($random(seed));
         lnk = (k == 0) ? 4'h0 : 4'($random(seed));
         if (mode[1:0] == 2'h2) mode[1:0] = 2'h0;
         if (k == 1) cfg[7:4] = 4'hf;
         lnk = lnk & ~cfg[7:4];
         pin <= lnk ^ cfg[3:0];
         for (int p = 0; p < 4; p++) begin
            m = mode[2*p+:2];
            opn[p] = (m == 1) || (m != 2 && lnk[p]);
         end
         if (lnk == 4'h0) opn[0] = 1'b1;
         apb(1'b1, `ADDR_PORT_CFG, {20'h0, cfg});
         apb(1'b1, `ADDR_LOOP_CTRL, {24'h0, mode});
         repeat (4) @(posedge clk);
         apb(1'b0, `ADDR_LINK_STATUS, 32'h0);
         check(rd, {24'h0, opn, lnk}, "status");
         check(open, opn, "port open");
      end
      $display("link states done");
      apb(1'b1, `ADDR_PORT_CFG, 32'h0);
      apb(1'b1, `ADDR_LOOP_CTRL, 32'h0);
      for (int f = 0; f < 4; f++) begin
         pin <= (f == 3) ? 4'h7 : 4'h6;
         apb(1'b1, `ADDR_TX_SHIFT, (f == 2) ? 32'h100 : (f == 3) ? 32'h30 : 32'h0);
         repeat (4) @(posedge clk);
         q.delete();
         e.delete();
         for (int i = 0; i < 40; i++) q.push_back(4'($random(seed)));
         q[28][1] = f[0];
         foreach (q[i]) e.push_back({1'b0, q[i]});
         if (f < 3 && f[0] == 0) e[28][1] = 1'b1;
         if (f == 1) begin
            e = e[0:28];
            e[28][4] = 1'b1;
         end
         i_phy.send(1, q);
         wait (tx_en[2] === 1'b0);
         repeat (4) @(posedge lclk);
         @(posedge clk);
         check(i_phy.got[2].size(), e.size(), "frame length");
         foreach (e[i]) check(i_phy.got[2][i], e[i], "nibble");
         m = i_phy.got[0].size() + i_phy.got[1].size() + i_phy.got[3].size();
         check(m, 0, "stray frame");
         for (int p = 0; p < 4; p++) i_phy.got[p].delete();
         $display("frame %0d done", f);
      end
      // a start level of 16 keeps a whole short frame in the fifo before it is sent
      apb(1'b1, `ADDR_FWD_FIFO, 32'h10);
      q.delete();
      for (int i = 0; i < 15; i++) q.push_back(4'($random(seed)));
      i_phy.send(1, q);
      wait (tx_en[2] === 1'b1);
      wait (tx_en[2] === 1'b0);
      repeat (4) @(posedge lclk);
      @(posedge clk);
      apb(1'b0, `ADDR_LINK_STATUS, 32'h0);
      check(rd[8], 1'b0, "fifo full");
      check(i_phy.got[2].size(), q.size(), "fifo drain");
      foreach (q[i]) check(i_phy.got[2][i], {1'b0, q[i]}, "fifo drain");
      check(tx_en, 4'h0, "fifo empty");
      $display("fifo done");
      finish_test;
   end
endmodule : slave_port_loop_control_tb
